// >>> include/dpr_consts.vh
// Constants for the device 0 proxy register decode
`ifndef DPR_CONSTS_VH
`define DPR_CONSTS_VH

// Register select codes
`define DPR_SEL_NONE     3'h0
`define DPR_SEL_CTRL     3'h1
`define DPR_SEL_FEAT     3'h2
`define DPR_SEL_SECT     3'h3
`define DPR_SEL_LOW      3'h4
`define DPR_SEL_MID      3'h5
`define DPR_SEL_HIGH     3'h6
`define DPR_SEL_DEV      3'h7

// Address line patterns (DA2 DA1 DA0, 1 = asserted)
`define DPR_DA_CTRL      3'h6
`define DPR_DA_FEAT      3'h1
`define DPR_DA_SECT      3'h2
`define DPR_DA_LOW       3'h3
`define DPR_DA_MID       3'h4
`define DPR_DA_HIGH      3'h5
`define DPR_DA_DEV       3'h6

// Field positions
`define DPR_BIT_IEN      1
`define DPR_BIT_SOFT_RESET_BIT     2
`define DPR_BIT_DEVNUM   4

// Reset values
`define DPR_RST_CTRL     8'h00
`define DPR_RST_FEAT     8'h00
`define DPR_RST_SECT     8'h00
`define DPR_RST_LOW      8'h00
`define DPR_RST_MID      8'h00
`define DPR_RST_HIGH     8'h00
`define DPR_RST_DEV      8'h00

// Value driven for zero reads
`define DPR_ZERO_BYTE    8'h00

// Own logical device number
`define DPR_OWN_DEVNUM   1'b0

// Synchroniser depth
`define DPR_SYNC_STAGES  2

`endif

// >>> src/dpr_proxy_decode.v
// Device 0 task-file decode, answering while device 1 is selected
//
// Overview of operation
// R1: Alternate-select write at 110 loads control.
// R2: Alternate-status read answers zero byte.
// R3: Primary write at 001 stores feature.
// R4: Primary read at 001 returns error register.
// R5: Write at 010 loads sector count.
// R6: Read 010: count, or zero with packet.
// R7: Write at 011 loads low address byte.
// R8: Read 011: low byte, or zero with packet.
// R9: Write at 100 loads middle address byte.
// R10: Read 100: middle byte, or zero with packet.
// R11: Write at 101 loads high address byte.
// R12: Read 101: high byte, or zero with packet.
// R13: Write at 110 loads device-select, reacts.
// R14: Ignore unmapped chip select/address combinations.
// R15: Selected only when device bit matches own.
`include "dpr_consts.vh"
`default_nettype none

module dpr_proxy_decode (
  // Clock and reset
  input  wire       clk_in,
  input  wire       rst_in,
  // Host pins, active low strobes and selects
  input  wire       cs0_n_in,
  input  wire       cs1_n_in,
  input  wire [2:0] da_in,
  input  wire       dior_n_in,
  input  wire       diow_n_in,
  input  wire [7:0] dd_in,
  output wire [7:0] dd_out,
  output wire       dd_oe_out,
  // Device 0 state
  input  wire       proxy_enable_in,
  input  wire       packet_feature_in,
  input  wire       busy_flag_in,
  input  wire       data_request_flag_in,
  input  wire [7:0] error_in,
  // Register contents
  output wire       interrupt_disable_bit_out,
  output wire       soft_reset_bit_out,
  output wire [7:0] feature_out,
  output wire [7:0] sector_count_out,
  output wire [7:0] addr_low_out,
  output wire [7:0] addr_mid_out,
  output wire [7:0] addr_high_out,
  output wire [7:0] device_select_out,
  output wire       self_selected_out,
  output wire       proxy_active_out,
  output wire       write_taken_out
);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  wire [14:0] pins_async;
  wire [14:0] pins_sync;
  wire        cs0_n_s;
  wire        cs1_n_s;
  wire [2:0]  da_s;
  wire        dior_n_s;
  wire        diow_n_s;
  wire [7:0]  dd_s;

  assign pins_async = {cs0_n_in, cs1_n_in, da_in, dior_n_in, diow_n_in,
                       dd_in};

  // Reset leaves both selects and both strobes negated, so no false edge
  dpr_sync #(
    .WIDTH     (15),
    .RESET_VAL (15'h6300)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in (pins_async),
    .sync_out (pins_sync)
  );

  assign cs0_n_s  = pins_sync[14];
  assign cs1_n_s  = pins_sync[13];
  assign da_s     = pins_sync[12:10];
  assign dior_n_s = pins_sync[9];
  assign diow_n_s = pins_sync[8];
  assign dd_s     = pins_sync[7:0];

  ////////////////////////////////////////////////////////////////////
  // Address decode

  function [2:0] dpr_decode;
    input       cs0_n;
    input       cs1_n;
    input [2:0] da;
    begin
      dpr_decode = `DPR_SEL_NONE;
      if (!cs0_n && !cs1_n) begin
        dpr_decode = `DPR_SEL_NONE; // R14
      end else if (!cs1_n && da == `DPR_DA_CTRL) begin
        dpr_decode = `DPR_SEL_CTRL;
      end else if (!cs0_n && da == `DPR_DA_FEAT) begin
        dpr_decode = `DPR_SEL_FEAT;
      end else if (!cs0_n && da == `DPR_DA_SECT) begin
        dpr_decode = `DPR_SEL_SECT;
      end else if (!cs0_n && da == `DPR_DA_LOW) begin
        dpr_decode = `DPR_SEL_LOW;
      end else if (!cs0_n && da == `DPR_DA_MID) begin
        dpr_decode = `DPR_SEL_MID;
      end else if (!cs0_n && da == `DPR_DA_HIGH) begin
        dpr_decode = `DPR_SEL_HIGH;
      end else if (!cs0_n && da == `DPR_DA_DEV) begin
        dpr_decode = `DPR_SEL_DEV;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Registers

  reg       diow_n_last_reg;
  reg [2:0] wsel_last_reg;
  reg [7:0] wdata_last_reg;
  reg [7:0] ctrl_reg;
  reg [7:0] feat_reg;
  reg [7:0] sect_reg;
  reg [7:0] low_reg;
  reg [7:0] mid_reg;
  reg [7:0] high_reg;
  reg [7:0] dev_reg;
  reg [7:0] dd_out_reg;
  reg       dd_oe_reg;
  reg       write_taken_reg;

  wire       self_selected;
  wire       proxy_active;
  wire       idle;
  wire       write_end;
  wire       write_ok;
  wire [2:0] rsel;
  reg  [7:0] rdata_next;
  reg        rhit_next;

  assign self_selected = dev_reg[`DPR_BIT_DEVNUM] == `DPR_OWN_DEVNUM; // R15
  assign proxy_active  = !self_selected && proxy_enable_in;
  assign idle          = !busy_flag_in && !data_request_flag_in;

  // Write completes on the negation of the write strobe
  assign write_end = diow_n_s && !diow_n_last_reg;
  assign write_ok  = write_end && idle;

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      diow_n_last_reg <= 1'b1;
      wsel_last_reg   <= `DPR_SEL_NONE;
      wdata_last_reg  <= 8'h00;
    end else begin
      diow_n_last_reg <= diow_n_s;
      wsel_last_reg   <= dpr_decode(cs0_n_s, cs1_n_s, da_s);
      wdata_last_reg  <= dd_s;
    end
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_reg        <= `DPR_RST_CTRL;
      feat_reg        <= `DPR_RST_FEAT;
      sect_reg        <= `DPR_RST_SECT;
      low_reg         <= `DPR_RST_LOW;
      mid_reg         <= `DPR_RST_MID;
      high_reg        <= `DPR_RST_HIGH;
      dev_reg         <= `DPR_RST_DEV;
      write_taken_reg <= 1'b0;
    end else begin
      write_taken_reg <= write_ok && wsel_last_reg != `DPR_SEL_NONE;
      if (write_ok) begin
        case (wsel_last_reg)
          `DPR_SEL_CTRL: ctrl_reg <= wdata_last_reg; // R1
          `DPR_SEL_FEAT: feat_reg <= wdata_last_reg; // R3
          `DPR_SEL_SECT: sect_reg <= wdata_last_reg; // R5
          `DPR_SEL_LOW:  low_reg  <= wdata_last_reg; // R7
          `DPR_SEL_MID:  mid_reg  <= wdata_last_reg; // R9
          `DPR_SEL_HIGH: high_reg <= wdata_last_reg; // R11
          `DPR_SEL_DEV:  dev_reg  <= wdata_last_reg; // R13
          default: ;                                 // R14
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read path, answered only while standing in for device 1

  assign rsel = dpr_decode(cs0_n_s, cs1_n_s, da_s);

  always @* begin
    rhit_next  = !dior_n_s && diow_n_s && proxy_active && idle;
    rdata_next = `DPR_ZERO_BYTE;
    case (rsel)
      `DPR_SEL_CTRL: rdata_next = `DPR_ZERO_BYTE; // R2
      `DPR_SEL_FEAT: rdata_next = error_in;       // R4
      `DPR_SEL_SECT:
        rdata_next = packet_feature_in ? `DPR_ZERO_BYTE : sect_reg; // R6
      `DPR_SEL_LOW:
        rdata_next = packet_feature_in ? `DPR_ZERO_BYTE : low_reg;  // R8
      `DPR_SEL_MID:
        rdata_next = packet_feature_in ? `DPR_ZERO_BYTE : mid_reg;  // R10
      `DPR_SEL_HIGH:
        rdata_next = packet_feature_in ? `DPR_ZERO_BYTE : high_reg; // R12
      `DPR_SEL_DEV:
        rdata_next = packet_feature_in ? `DPR_ZERO_BYTE :
                     (dev_reg | (8'h01 << `DPR_BIT_DEVNUM));
      default: rhit_next = 1'b0;                  // R14
    endcase
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dd_out_reg <= 8'h00;
      dd_oe_reg  <= 1'b0;
    end else begin
      dd_oe_reg  <= rhit_next;
      dd_out_reg <= rhit_next ? rdata_next : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  assign dd_out                    = dd_out_reg;
  assign dd_oe_out                 = dd_oe_reg;
  assign interrupt_disable_bit_out = ctrl_reg[`DPR_BIT_IEN];  // R1
  assign soft_reset_bit_out        = ctrl_reg[`DPR_BIT_SOFT_RESET_BIT]; // R1
  assign feature_out               = feat_reg;
  assign sector_count_out          = sect_reg;
  assign addr_low_out              = low_reg;
  assign addr_mid_out              = mid_reg;
  assign addr_high_out             = high_reg;
  assign device_select_out         = dev_reg;
  assign self_selected_out         = self_selected;           // R13
  assign proxy_active_out          = proxy_active;
  assign write_taken_out           = write_taken_reg;

endmodule // dpr_proxy_decode

`default_nettype wire

// >>> src/dpr_sync.v
// Two-flop synchroniser for a vector of pin inputs
`default_nettype none

module dpr_sync #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset
  input  wire             clk_in,
  input  wire             rst_in,
  // Data
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] stable_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          meta_reg[i]   <= RESET_VAL[i];
          stable_reg[i] <= RESET_VAL[i];
        end else begin
          meta_reg[i]   <= async_in[i];
          stable_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

  assign sync_out = stable_reg;

endmodule // dpr_sync

`default_nettype wire

// >>> verif/dpr_host_model.sv
// Host adapter model driving selects, address, strobes and data
`default_nettype none
module dpr_host_model (
  // Clock and device data
  input  wire logic       clk_in,
  input  wire logic [7:0] dd_out_in,
  input  wire logic       dd_oe_in,
  // Host pins
  output logic            cs0_n_out,
  output logic            cs1_n_out,
  output logic            dior_n_out,
  output logic            diow_n_out,
  output logic [2:0]      da_out,
  output logic [7:0]      dd_to_dev_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] hd = 8'h00;
  logic       hdrv = 1'b0;
  initial begin
    {cs0_n_out, cs1_n_out, dior_n_out, diow_n_out, da_out} = 7'h7F;
  end
  // Undriven bus shows the inverse of the last host byte
  assign dd_to_dev_out = dd_oe_in ? dd_out_in : (hdrv ? hd : ~hd);
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // Strobe low 5 cycles, high 4 more with selects and data held
  task automatic xfer(input logic wr, input logic alt, input logic [2:0] a,
                      input logic [7:0] d, output logic [7:0] q,
                      output logic o);
    cyc(1);
    cs0_n_out = alt;
    cs1_n_out = !alt;
    da_out = a;
    hd = d;
    hdrv = wr;
    diow_n_out = !wr;
    dior_n_out = wr;
    cyc(5);
    q = dd_out_in;
    o = dd_oe_in;
    dior_n_out = 1'b1;
    diow_n_out = 1'b1;
    cyc(4);
    cs0_n_out = 1'b1;
    cs1_n_out = 1'b1;
    hdrv = 1'b0;
  endtask
endmodule // dpr_host_model
`default_nettype wire

// >>> verif/dpr_proxy_decode_asserts.sv
// Checker for the device 0 proxy register decode
`default_nettype none
module dpr_proxy_decode_chk (
  input wire logic       clk_in, rst_in, cs0_n_in, cs1_n_in,
  input wire logic [2:0] da_in,
  input wire logic [7:0] dd_in, error_in, dd_out,
  input wire logic       busy_flag_in, data_request_flag_in,
  input wire logic       packet_feature_in, proxy_enable_in, dd_oe_out,
  input wire logic       interrupt_disable_bit_out, soft_reset_bit_out,
  input wire logic [7:0] feature_out, sector_count_out, device_select_out,
  input wire logic       self_selected_out, write_taken_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Read driven, selected chip select three cycles back
  sequence s_rd(alt);
    dd_oe_out && $past(cs0_n_in, 3) == alt;
  endsequence
  a_idle_zero: assert property (!dd_oe_out |-> dd_out == 8'h00)
    else $error("dd_out not zero while idle");
  a_alt_zero: assert property (s_rd(1) |-> dd_out == 8'h00)
    else $error("alternate status read not zero");
  a_err_read: assert property (s_rd(0) ##0 $past(da_in, 3) == 3'h1
    |-> dd_out == $past(error_in)) else $error("error read wrong");
  a_pkt_zero: assert property (s_rd(0) ##0 ($past(packet_feature_in)
    && $past(da_in, 3) inside {[2:6]}) |-> dd_out == 8'h00)
    else $error("packet read not zero");
  a_sect_read: assert property (s_rd(0) ##0 (!$past(packet_feature_in)
    && $past(da_in, 3) == 3'h2) |-> dd_out == sector_count_out)
    else $error("sector count read wrong");
  a_dev_read: assert property (s_rd(0) ##0 (!$past(packet_feature_in)
    && $past(da_in, 3) == 3'h6) |-> dd_out == (device_select_out | 8'h10))
    else $error("device read wrong");
  a_taken_idle: assert property (write_taken_out |->
    !$past(busy_flag_in) && !$past(data_request_flag_in))
    else $error("write taken while busy");
  a_taken_decode: assert property (write_taken_out |->
    $past(cs0_n_in, 3) != $past(cs1_n_in, 3)
    && !($past(da_in, 3) inside {3'h0, 3'h7})
    && (!$past(cs0_n_in, 3) || $past(da_in, 3) == 3'h6))
    else $error("unmapped write taken");
  a_ctrl_load: assert property (write_taken_out && !$past(cs1_n_in, 3)
    |-> {soft_reset_bit_out, interrupt_disable_bit_out, 1'b0}
    == ($past(dd_in, 3) & 8'h06)) else $error("control bits wrong");
  a_regs_hold: assert property (!write_taken_out |-> $stable(feature_out)
    && $stable(sector_count_out) && $stable(device_select_out))
    else $error("register changed without write");
  a_read_proxy: assert property (dd_oe_out |-> $past(proxy_enable_in)
    && !$past(busy_flag_in) && !$past(self_selected_out))
    else $error("read answered outside proxy");
endmodule // dpr_proxy_decode_chk
bind dpr_proxy_decode dpr_proxy_decode_chk chk_u (.*);
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the device 0 proxy register decode
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 0, rst_in = 1, pen = 0, pkt = 0, busy_flag = 0, data_request_flag = 0, oe;
  logic [7:0] err = 8'h00, q, m [1:6];
  logic [31:0] lf = 32'h8C53;
  int n_fail = 0, compares = 0, cyc_n = 0, i, k;
  wire logic cs0_n, cs1_n, rd_n, wr_n, ien, soft_reset_bit, ssel, pact, wt, doe;
  wire logic [2:0] da;
  wire logic [7:0] dd, dout, r [1:6];
  dpr_host_model host_u (.clk_in(clk_in), .dd_out_in(dout), .dd_oe_in(doe),
    .cs0_n_out(cs0_n), .cs1_n_out(cs1_n), .dior_n_out(rd_n),
    .diow_n_out(wr_n), .da_out(da), .dd_to_dev_out(dd));
  dpr_proxy_decode dut_u (.clk_in(clk_in), .rst_in(rst_in),
    .cs0_n_in(cs0_n), .cs1_n_in(cs1_n), .da_in(da), .dior_n_in(rd_n),
    .diow_n_in(wr_n), .dd_in(dd), .dd_out(dout), .dd_oe_out(doe),
    .proxy_enable_in(pen), .packet_feature_in(pkt), .busy_flag_in(busy_flag),
    .data_request_flag_in(data_request_flag), .error_in(err),
    .interrupt_disable_bit_out(ien), .soft_reset_bit_out(soft_reset_bit),
    .feature_out(r[1]), .sector_count_out(r[2]), .addr_low_out(r[3]),
    .addr_mid_out(r[4]), .addr_high_out(r[5]), .device_select_out(r[6]),
    .self_selected_out(ssel), .proxy_active_out(pact),
    .write_taken_out(wt));
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected read byte for scan index k (0 unmapped, 7 alternate status)
  function automatic logic [7:0] exp_rd(input int k);
    if (k == 0 || k == 7) return 8'h00;
    if (k == 1) return err;
    if (pkt) return 8'h00;
    return (k == 6) ? (m[6] | 8'h10) : m[k];
  endfunction
  task automatic report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc_n++;
    if (cyc_n == 1500) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    repeat (8) @(posedge clk_in);
    #1 rst_in = 0;
    pen = 1;
    `CHK(ssel, 1'b1)
    host_u.cyc(3);
    for (i = 1; i < 7; i++) begin
      lf = nx(lf);
      m[i] = (i == 6) ? (lf[7:0] | 8'h10) : lf[7:0];
      host_u.xfer(1, 0, i[2:0], m[i], q, oe);
      `CHK(r[i], m[i])
    end
    `CHK({ssel, pact}, 2'b01)
    host_u.xfer(1, 1, 3'h6, lf[15:8], q, oe);
    `CHK({soft_reset_bit, ien}, lf[10:9])
    data_request_flag = 1;
    host_u.xfer(1, 0, 3'h2, ~m[2], q, oe);
    data_request_flag = 0;
    host_u.xfer(1, 0, 3'h0, 8'hFF, q, oe);
    host_u.xfer(1, 0, 3'h7, 8'hFF, q, oe);
    host_u.xfer(1, 1, 3'h5, 8'hFF, q, oe);
    host_u.xfer(1, 1, 3'h7, 8'hFF, q, oe);
    for (i = 1; i < 7; i++) `CHK(r[i], m[i])
    `CHK({soft_reset_bit, ien}, lf[10:9])
    for (i = 0; i < 2; i++) begin
      pkt = i[0];
      for (k = 0; k < 8; k++) begin
        lf = nx(lf);
        err = lf[7:0];
        host_u.xfer(0, k == 7, (k == 7) ? 3'h6 : k[2:0], 8'h00, q, oe);
        `CHK(oe, k != 0)
        `CHK(q, exp_rd(k))
      end
    end
    busy_flag = 1;
    host_u.xfer(0, 0, 3'h3, 8'h00, q, oe);
    busy_flag = 0;
    `CHK(oe, 1'b0)
    host_u.xfer(1, 0, 3'h6, 8'h00, q, oe);
    host_u.xfer(0, 0, 3'h2, 8'h00, q, oe);
    `CHK({ssel, oe}, 2'b10)
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
